//--- rtl/emps_defines.svh
/*
 * Constants of the transceiver mode and port control block: timing
 * counts, pin codes, register offsets, field positions, reset values.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef EMPS_DEFINES_SVH
`define EMPS_DEFINES_SVH

`define EMPS_CLK_PERIOD_NS   100
`define EMPS_SETTLE_TIME_NS  1000000
`define EMPS_SETTLE_CYCLES   (`EMPS_SETTLE_TIME_NS / `EMPS_CLK_PERIOD_NS)

`define EMPS_SQE_DELAY_MIN   6
`define EMPS_SQE_DELAY_MAX   16
`define EMPS_SQE_HOLD_MIN    5
`define EMPS_SQE_HOLD_MAX    15
`define EMPS_SQE_DELAY_BT    8
`define EMPS_SQE_HOLD_BT     10

`define EMPS_CS_IFACE_A      3'h3
`define EMPS_CS_IFACE_B      3'h2
`define EMPS_CS_IFACE_C      3'h1
`define EMPS_CS_IFACE_D      3'h0

`define EMPS_REG_CTRL        4'h0
`define EMPS_REG_STATUS      4'h4
`define EMPS_REG_PORTCHG     4'h8
`define EMPS_CTRL_STANDBY    0
`define EMPS_CTRL_HOLD       1
`define EMPS_CTRL_RESET      2'h0
`define EMPS_CFG_RESET       9'h067
`define EMPS_RESP_OKAY       2'h0
`define EMPS_RESP_SLVERR     2'h2

`endif

//--- rtl/emps_pkg.sv
/*
 * Types of the transceiver mode and port control block.
 * Assumes nothing of its surroundings.
 */
package emps_pkg;

    typedef enum logic [1:0] {
        EMPS_PORT_AUI = 2'b01,
        EMPS_PORT_TP  = 2'b10
    } emps_port_t;

    typedef enum logic [2:0] {
        EMPS_HB_IDLE  = 3'b001,
        EMPS_HB_WAIT  = 3'b010,
        EMPS_HB_PULSE = 3'b100
    } emps_hb_t;

    typedef enum logic [4:0] {
        EMPS_IF_A       = 5'b00001,
        EMPS_IF_B       = 5'b00010,
        EMPS_IF_C       = 5'b00100,
        EMPS_IF_D       = 5'b01000,
        EMPS_IF_STANDBY = 5'b10000
    } emps_iface_t;

    typedef struct packed {
        logic       loop;
        logic       auto_sel;
        logic       hb_n;
        logic       fdx_n;
        logic       pol_en;
        logic       port_select_io;
        logic [2:0] cs;
    } emps_cfg_t;

endpackage

//--- rtl/emps_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level or is only edge-detected downstream.
 */
`timescale 1ns/100ps
`default_nettype none

module emps_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // emps_sync

`default_nettype wire

//--- rtl/emps_top.sv
/*
 * Mode decode, port selection, loopback, heartbeat and collision
 * reporting of a two-port 10 Mb/s transceiver, with an AXI4-Lite slave.
 * Assumes all pins come from other clock domains and the oscillator
 * input is slow enough to be edge-sampled by sys_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "emps_defines.svh"

module emps_top
    import emps_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = `EMPS_SETTLE_CYCLES,
    parameter int unsigned SQE_DELAY_BT  = `EMPS_SQE_DELAY_BT,
    parameter int unsigned SQE_HOLD_BT   = `EMPS_SQE_HOLD_BT
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output var  logic        s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output var  logic        s_axi_wready_o,
    output var  logic [1:0]  s_axi_bresp_o,
    output var  logic        s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output var  logic        s_axi_arready_o,
    output var  logic [31:0] s_axi_rdata_o,
    output var  logic [1:0]  s_axi_rresp_o,
    output var  logic        s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        iface_select_bit0_i,
    input  wire logic        iface_select_bit1_i,
    input  wire logic        iface_select_bit2_i,
    input  wire logic        loopback_en_i,
    input  wire logic        auto_port_select_en_i,
    input  wire logic        heartbeat_test_en_n_i,
    input  wire logic        full_duplex_sel_n_i,
    input  wire logic        polarity_correct_en_i,
    input  wire logic        port_select_io_i,
    output var  logic        port_select_io_o,
    output var  logic        port_select_io_oe_o,
    output var  logic        polarity_fault_out_n_o,
    output var  logic        polarity_fault_out_n_oe_o,
    input  wire logic        osc_in_i,
    input  wire logic        tx_data_i,
    input  wire logic        tx_en_i,
    output var  logic        tx_clock_out_o,
    output var  logic        rx_data_o,
    output var  logic        collision_out_o,
    output var  logic        ctrl_oe_o,
    input  wire logic        tp_link_ok_i,
    input  wire logic        tp_polarity_rev_i,
    input  wire logic        tp_rx_data_i,
    input  wire logic        tp_rx_active_i,
    input  wire logic        aui_rx_data_i,
    input  wire logic        aui_rx_active_i,
    input  wire logic        aui_collision_rx_i,
    output var  logic        tp_tx_data_o,
    output var  logic        tp_tx_en_o,
    output var  logic        tp_link_pulse_en_o,
    output var  logic        tp_idle_o,
    output var  logic        aui_tx_data_o,
    output var  logic        aui_tx_en_o,
    output var  logic        aui_idle_o
);

    localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);

    logic [18:0] pins_s;
    emps_cfg_t   cfg_live, cfg_q, cfg_d;
    logic        osc_s, txd_s, txen_s, link_s, rev_s, tprxd_s, tpact_s;
    logic        auirxd_s, auiact_s, auicol_s;

    emps_sync #(
        .WIDTH (19)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .async_i   ({iface_select_bit2_i, iface_select_bit1_i,
                     iface_select_bit0_i, loopback_en_i,
                     auto_port_select_en_i, heartbeat_test_en_n_i,
                     full_duplex_sel_n_i, polarity_correct_en_i,
                     port_select_io_i, osc_in_i, tx_data_i, tx_en_i,
                     tp_link_ok_i, tp_polarity_rev_i, tp_rx_data_i,
                     tp_rx_active_i, aui_rx_data_i, aui_rx_active_i,
                     aui_collision_rx_i}),
        .sync_o    (pins_s)
    );

    assign cfg_live = {pins_s[15], pins_s[14], pins_s[13], pins_s[12],
                       pins_s[11], pins_s[10], pins_s[18:16]};
    assign {osc_s, txd_s, txen_s, link_s, rev_s, tprxd_s, tpact_s,
            auirxd_s, auiact_s, auicol_s} = pins_s[9:0];

    logic [1:0]  ctrl_q, ctrl_d;
    emps_port_t  port_q, port_d;
    emps_hb_t    hb_q, hb_d;
    emps_iface_t iface;
    logic        standby, loop, tp_sel, settled, pol_fault;

    always_comb begin
        case (cfg_q.cs)
            `EMPS_CS_IFACE_A: iface = EMPS_IF_A;
            `EMPS_CS_IFACE_B: iface = EMPS_IF_B;
            `EMPS_CS_IFACE_C: iface = EMPS_IF_C;
            `EMPS_CS_IFACE_D: iface = EMPS_IF_D;
            default:          iface = EMPS_IF_STANDBY;
        endcase
    end

    // Software may force standby on top of the pin code.
    assign standby = (iface == EMPS_IF_STANDBY) |
                     ctrl_q[`EMPS_CTRL_STANDBY];
    assign loop    = cfg_q.loop;
    assign tp_sel  = (port_q == EMPS_PORT_TP);
    // Polarity checking ignores loopback on purpose.
    assign pol_fault = cfg_q.pol_en & rev_s & link_s;

    // Oscillator edges, transmit clock and Manchester datapath.
    logic osc_prev_q, osc_prev_d, tx_clk_q, tx_clk_d, man_q, man_d;
    logic txd_q, txd_d, txen_q, txen_d, rxd_q, rxd_d;
    logic osc_rise, bit_en, tx_end, frame_idle;

    assign osc_rise = osc_s & ~osc_prev_q;
    assign bit_en   = osc_rise & ~tx_clk_q;
    assign tx_end   = bit_en & txen_q & ~txen_s;

    always_comb begin
        osc_prev_d = osc_s;
        tx_clk_d   = tx_clk_q ^ osc_rise;
        cfg_d      = bit_en ? cfg_live : cfg_q;
        txd_d      = bit_en ? txd_s : txd_q;
        txen_d     = bit_en ? (txen_s & ~standby) : txen_q;
        man_d      = man_q;
        if (osc_rise) begin
            man_d = bit_en ? ~txd_s : txd_q;
        end
        rxd_d = rxd_q;
        if (bit_en) begin
            if (standby) begin
                rxd_d = 1'b0;
            end else if (loop) begin
                rxd_d = man_q;
            end else if (!settled) begin
                rxd_d = 1'b0;
            end else if (tp_sel) begin
                rxd_d = tprxd_s ^ (cfg_q.pol_en & rev_s);
            end else begin
                rxd_d = auirxd_s;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            osc_prev_q <= 1'b0;
            tx_clk_q   <= 1'b0;
            cfg_q      <= emps_cfg_t'(`EMPS_CFG_RESET);
            txd_q      <= 1'b0;
            txen_q     <= 1'b0;
            man_q      <= 1'b0;
            rxd_q      <= 1'b0;
        end else begin
            osc_prev_q <= osc_prev_d;
            tx_clk_q   <= tx_clk_d;
            cfg_q      <= cfg_d;
            txd_q      <= txd_d;
            txen_q     <= txen_d;
            man_q      <= man_d;
            rxd_q      <= rxd_d;
        end
    end

    // Port selection with settling time after each change.
    logic [SW-1:0] settle_q, settle_d;
    logic [15:0]   chg_q, chg_d;
    emps_port_t    want;

    assign settled    = (settle_q == '0);
    assign frame_idle = ~txen_q & ~txen_s & ~tpact_s & ~auiact_s;

    always_comb begin
        if (cfg_q.auto_sel) begin
            want = (link_s | tpact_s) ? EMPS_PORT_TP
                                      : EMPS_PORT_AUI;
        end else begin
            want = cfg_q.port_select_io ? EMPS_PORT_TP : EMPS_PORT_AUI;
        end
        port_d   = port_q;
        chg_d    = chg_q;
        settle_d = settle_q;
        if (bit_en && frame_idle && want != port_q &&
            !(cfg_q.auto_sel && ctrl_q[`EMPS_CTRL_HOLD])) begin
            port_d   = want;
            settle_d = SW'(SETTLE_CYCLES - 1);
            chg_d    = chg_q + 16'h0001;
        end else if (!settled) begin
            settle_d = settle_q - SW'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            port_q   <= EMPS_PORT_AUI;
            settle_q <= '0;
            chg_q    <= 16'h0000;
        end else begin
            port_q   <= port_d;
            settle_q <= settle_d;
            chg_q    <= chg_d;
        end
    end

    // Heartbeat timer counted in transmit clock periods.
    logic [4:0] bt_q, bt_d;
    logic       col_q, col_d, hb_ok, tp_col;

    // The test only touches the collision path, never the line.
    assign hb_ok  = ~cfg_q.hb_n & tp_sel & ~standby;
    assign tp_col = txen_q & tpact_s & cfg_q.fdx_n;

    always_comb begin
        hb_d = hb_q;
        bt_d = bt_q;
        case (hb_q)
            EMPS_HB_IDLE: begin
                if (tx_end && hb_ok) begin
                    hb_d = EMPS_HB_WAIT;
                    bt_d = 5'h00;
                end
            end
            EMPS_HB_WAIT: begin
                if (bit_en) begin
                    if (bt_q == 5'(SQE_DELAY_BT - 1)) begin
                        hb_d = EMPS_HB_PULSE;
                        bt_d = 5'h00;
                    end else begin
                        bt_d = bt_q + 5'h01;
                    end
                end
            end
            EMPS_HB_PULSE: begin
                if (bit_en) begin
                    if (bt_q == 5'(SQE_HOLD_BT - 1)) begin
                        hb_d = EMPS_HB_IDLE;
                    end else begin
                        bt_d = bt_q + 5'h01;
                    end
                end
            end
            default: begin
                hb_d = EMPS_HB_IDLE;
                bt_d = 5'h00;
            end
        endcase
        col_d = ~standby & ((hb_q == EMPS_HB_PULSE) |
                (~loop & settled & (tp_sel ? tp_col : auicol_s)));
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            hb_q  <= EMPS_HB_IDLE;
            bt_q  <= 5'h00;
            col_q <= 1'b0;
        end else begin
            hb_q  <= hb_d;
            bt_q  <= bt_d;
            col_q <= col_d;
        end
    end

    // Pins toward the controller and the media.
    assign ctrl_oe_o       = ~standby;
    assign tx_clock_out_o  = tx_clk_q;
    assign rx_data_o       = rxd_q;
    assign collision_out_o = col_q;
    assign tp_tx_data_o    = man_q;
    assign aui_tx_data_o   = man_q;
    assign tp_tx_en_o  = txen_q & ~loop & settled & tp_sel;
    assign aui_tx_en_o = txen_q & ~loop & settled & ~tp_sel;
    assign tp_link_pulse_en_o = ~standby & (tp_sel | cfg_q.auto_sel);
    assign tp_idle_o   = standby | (~tp_sel & ~cfg_q.auto_sel);
    assign aui_idle_o  = standby | tp_sel;
    assign port_select_io_o    = tp_sel;
    assign port_select_io_oe_o = cfg_q.auto_sel & ~standby;
    assign polarity_fault_out_n_o    = ~pol_fault;
    assign polarity_fault_out_n_oe_o = ~standby & tp_sel;

    // AXI4-Lite slave; address and data may arrive in either order.
    logic        aw_got_q, aw_got_d, w_got_q, w_got_d, bv_q, bv_d;
    logic        rv_q, rv_d;
    logic [3:0]  awa_q, awa_d;
    logic [1:0]  wd_q, wd_d, bresp_q, bresp_d, rresp_q, rresp_d;
    logic        ws_q, ws_d;
    logic [31:0] rdata_q, rdata_d;

    assign s_axi_awready_o = ~aw_got_q & ~bv_q;
    assign s_axi_wready_o  = ~w_got_q & ~bv_q;
    assign s_axi_bvalid_o  = bv_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ~rv_q;
    assign s_axi_rvalid_o  = rv_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    always_comb begin
        aw_got_d = aw_got_q;
        awa_d    = awa_q;
        w_got_d  = w_got_q;
        wd_d     = wd_q;
        ws_d     = ws_q;
        bv_d     = bv_q & ~s_axi_bready_i;
        bresp_d  = bresp_q;
        ctrl_d   = ctrl_q;
        rv_d     = rv_q & ~s_axi_rready_i;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_d = 1'b1;
            awa_d    = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_d = 1'b1;
            wd_d    = s_axi_wdata_i[1:0];
            ws_d    = s_axi_wstrb_i[0];
        end
        if (aw_got_q && w_got_q) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bv_d     = 1'b1;
            bresp_d  = `EMPS_RESP_OKAY;
            case (awa_q)
                `EMPS_REG_CTRL: begin
                    if (ws_q) begin
                        ctrl_d = wd_q;
                    end
                end
                `EMPS_REG_STATUS, `EMPS_REG_PORTCHG: begin
                end
                default: bresp_d = `EMPS_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rv_d    = 1'b1;
            rresp_d = `EMPS_RESP_OKAY;
            case (s_axi_araddr_i)
                `EMPS_REG_CTRL:    rdata_d = {30'h0, ctrl_q};
                `EMPS_REG_STATUS:  rdata_d = {16'h0, hb_q, iface,
                    cfg_q.auto_sel, loop, pol_fault, link_s, settled,
                    standby, port_q};
                `EMPS_REG_PORTCHG: rdata_d = {16'h0, chg_q};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = `EMPS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            aw_got_q <= 1'b0;
            awa_q    <= 4'h0;
            w_got_q  <= 1'b0;
            wd_q     <= 2'h0;
            ws_q     <= 1'b0;
            bv_q     <= 1'b0;
            bresp_q  <= `EMPS_RESP_OKAY;
            ctrl_q   <= `EMPS_CTRL_RESET;
            rv_q     <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `EMPS_RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            awa_q    <= awa_d;
            w_got_q  <= w_got_d;
            wd_q     <= wd_d;
            ws_q     <= ws_d;
            bv_q     <= bv_d;
            bresp_q  <= bresp_d;
            ctrl_q   <= ctrl_d;
            rv_q     <= rv_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // Bit times spent in each heartbeat state, for checking only.
    logic [4:0] chk_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            chk_cnt_q <= 5'h00;
        end else if (hb_d != hb_q) begin
            chk_cnt_q <= 5'h00;
        end else if (bit_en) begin
            chk_cnt_q <= chk_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_standby_float: assert property (standby |-> !ctrl_oe_o &&
        !port_select_io_oe_o && !polarity_fault_out_n_oe_o)
        else $error("pins driven in standby");
    chk_loop_no_tx: assert property (loop |->
        !tp_tx_en_o && !aui_tx_en_o) else $error("tx during loopback");
    chk_loop_rx: assert property (loop && !standby && bit_en
        |=> rx_data_o == $past(man_q)) else $error("loopback data lost");
    chk_hb_delay: assert property (hb_q == EMPS_HB_WAIT &&
        hb_d == EMPS_HB_PULSE |-> (chk_cnt_q + 5'h01) inside {[6:16]})
        else $error("heartbeat start out of window");
    chk_hb_hold: assert property (hb_q == EMPS_HB_PULSE &&
        hb_d == EMPS_HB_IDLE |-> (chk_cnt_q + 5'h01) inside {[5:15]})
        else $error("heartbeat length out of window");
    chk_hb_col: assert property (hb_q == EMPS_HB_PULSE
        |=> collision_out_o) else $error("heartbeat not on collision");
    chk_aui_col: assert property (!tp_sel && !loop && settled &&
        !standby |=> collision_out_o == $past(auicol_s))
        else $error("attachment collision not passed");
    chk_fdx_quiet: assert property (!cfg_q.fdx_n && tp_sel &&
        hb_q == EMPS_HB_IDLE |=> !collision_out_o)
        else $error("collision in full duplex");
    chk_link_pol: assert property (!link_s |->
        polarity_fault_out_n_o) else $error("polarity low on link fail");
    chk_port_drive: assert property (cfg_q.auto_sel && !standby
        |-> port_select_io_oe_o && port_select_io_o == tp_sel)
        else $error("port pin not driven");
    chk_manual_aui: assert property (!cfg_q.auto_sel && !tp_sel
        |-> tp_idle_o && !tp_link_pulse_en_o)
        else $error("manual attachment port not idle");
    chk_txclk_half: assert property (osc_rise |=>
        tx_clock_out_o != $past(tx_clock_out_o)) else $error("tx clock");
    chk_settle_quiet: assert property ($changed(port_q) |->
        !settled ##1 !tp_tx_en_o && !aui_tx_en_o)
        else $error("traffic before settling");

    cov_loop_hb: cover property (loop && hb_q == EMPS_HB_PULSE);
    cov_auto_sw: cover property (cfg_q.auto_sel && $changed(port_q));
    cov_aui_col: cover property (!tp_sel && collision_out_o);
    cov_standby: cover property ($rose(standby));

endmodule // emps_top

`default_nettype wire

//--- verif/emps_ctl_model.sv
/* Controller model: sends random NRZ frames on the transmit clock and
 * records receive data. Assumes the block's clock and transmit clock. */
`timescale 1ns/100ps
`default_nettype none
module emps_ctl_model (
    input  wire logic sys_clk_i,
    input  wire logic tck_i,
    input  wire logic rx_i,
    output var  logic tx_en_o,
    output var  logic tx_data_o
);
    int   seed = 32'h8f043bb7;
    int   left = 0;
    logic tck_q = 1'b0;
    logic tck_r = 1'b0;
    logic b;
    bit   sent[$];
    bit   got[$];
    initial {tx_en_o, tx_data_o} = 2'b00;
    task automatic send(input int n);
        left = n;
        wait (left == 0);
    endtask
    // Receive data is taken a cycle late, after it settles
    always @(posedge sys_clk_i) begin
        tck_q <= tck_i;
        tck_r <= tck_q;
        if (tck_q && !tck_r) got.push_back(rx_i);
        if (tck_i && !tck_q) begin
            b = (left > 0) ? 1'($random(seed)) : !tx_data_o;
            if (left > 0) sent.push_back(b);
            tx_en_o <= (left > 0);
            tx_data_o <= b;
            left = (left > 0) ? left - 1 : 0;
        end
    end
endmodule // emps_ctl_model
`default_nettype wire

//--- verif/tb_eth_xcvr_mode_port_select.sv
/* Self-checking bench of the mode and port block.
 * Assumes emps_top and emps_ctl_model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_eth_xcvr_mode_port_select;
    logic sys_clk_i = 0, rst_b_i = 0, osc_in_i = 0, tx_data_i, tx_en_i;
    logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 4'hf;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, q;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0,
    s_axi_arvalid_i = 0, s_axi_rready_i = 0, iface_select_bit0_i = 1,
    iface_select_bit1_i = 1, iface_select_bit2_i = 0, loopback_en_i = 0,
    auto_port_select_en_i = 1, heartbeat_test_en_n_i = 0, man_q = 0,
    full_duplex_sel_n_i = 1, polarity_correct_en_i = 1, leak = 0,
    tp_link_ok_i = 1, tp_polarity_rev_i = 0, tp_rx_data_i = 0,
    tp_rx_active_i = 0, aui_rx_data_i = 0, aui_rx_active_i = 0,
    aui_collision_rx_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o,
    s_axi_rvalid_o, port_select_io_o, port_select_io_oe_o, ctrl_oe_o,
    polarity_fault_out_n_o, polarity_fault_out_n_oe_o, tx_clock_out_o,
    rx_data_o, collision_out_o, tp_tx_data_o, tp_tx_en_o, tp_idle_o,
    tp_link_pulse_en_o, aui_tx_data_o, aui_tx_en_o, aui_idle_o;
    wire port_select_io_i = port_select_io_oe_o ? port_select_io_o : man_q;
    int errors = 0, checks = 0, seed = 32'h8f043bb7, d, h;
    emps_top #(.SETTLE_CYCLES(20)) emps_top_inst (.*);
    emps_ctl_model emps_ctl_model_inst (.sys_clk_i(sys_clk_i),
    .tck_i(tx_clock_out_o), .rx_i(rx_data_o), .tx_en_o(tx_en_i),
    .tx_data_o(tx_data_i));
    initial forever #50 sys_clk_i = ~sys_clk_i;
    initial forever #400 osc_in_i = ~osc_in_i;
    initial begin
        #3000000 errors++;
        close_out;
    end
    always @(posedge sys_clk_i) begin
        tp_rx_data_i <= 1'($random(seed));
        aui_rx_data_i <= 1'($random(seed));
        if (loopback_en_i && (tp_tx_en_o || aui_tx_en_o)) leak <= 1;
    end
    // Values are taken at the call; callers make the call once they have
    // settled.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        @(negedge sys_clk_i);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
        @(posedge sys_clk_i);
    endtask
    // Ends off the edge, so a compare right after it sees settled outputs.
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] r);
        logic [1:0] rr;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        do @(negedge sys_clk_i); while (!s_axi_arready_o);
        @(posedge sys_clk_i) s_axi_arvalid_i <= 0;
        do @(negedge sys_clk_i); while (!s_axi_rvalid_o);
        q = s_axi_rdata_o;
        rr = s_axi_rresp_o;
        @(posedge sys_clk_i) s_axi_rready_i <= 0;
        chk(rr, r);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        logic [1:0] rr;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        do @(negedge sys_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
        @(posedge sys_clk_i) s_axi_awvalid_i <= 0;
        s_axi_wvalid_i <= 0;
        do @(negedge sys_clk_i); while (!s_axi_bvalid_o);
        rr = s_axi_bresp_o;
        @(posedge sys_clk_i) s_axi_bready_i <= 0;
        chk(rr, r);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1;
        for (int c = 0; c < 9; c++) begin
            {iface_select_bit2_i, iface_select_bit1_i, iface_select_bit0_i}
                <= (c < 8) ? 3'(c) : 3'h3;
            cyc(80);
            chk({ctrl_oe_o, port_select_io_oe_o}, {2{c < 4 || c > 7}});
        end
        $display("mode select done");
        chk(port_select_io_o, 1);
        tp_link_ok_i <= 0;
        cyc(120);
        chk({port_select_io_o, tp_link_pulse_en_o, tp_idle_o}, 3'b010);
        auto_port_select_en_i <= 0;
        cyc(80);
        chk({port_select_io_oe_o, tp_link_pulse_en_o, tp_idle_o}, 3'b001);
        aui_collision_rx_i <= 1;
        cyc(40);
        chk(collision_out_o, 1);
        aui_collision_rx_i <= 0;
        $display("port select done");
        {man_q, tp_link_ok_i, tp_polarity_rev_i} <= 3'b111;
        cyc(120);
        chk({polarity_fault_out_n_oe_o, polarity_fault_out_n_o}, 2'b10);
        rd(4'h4, 2'h0);
        chk(q[1:0], 2'b10);
        tp_link_ok_i <= 0;
        cyc(80);
        chk(polarity_fault_out_n_o, 1);
        wr(4'h0, 32'h3, 2'h0);
        rd(4'h0, 2'h0);
        chk(q[1:0], 2'b11);
        chk(ctrl_oe_o, 0);
        wr(4'h0, 32'h0, 2'h0);
        wr(4'hc, 32'h0, 2'h2);
        rd(4'hc, 2'h2);
        $display("polarity and bus done");
        {loopback_en_i, tp_link_ok_i} <= 2'b11;
        cyc(80);
        emps_ctl_model_inst.sent.delete();
        emps_ctl_model_inst.got.delete();
        emps_ctl_model_inst.send(24);
        @(negedge tx_en_i);
        for (d = 0; !collision_out_o && d < 600; d++) @(negedge sys_clk_i);
        for (h = 0; collision_out_o && h < 600; h++) @(negedge sys_clk_i);
        chk(d / 16 inside {[6:16]} && h / 16 inside {[5:15]}, 1);
        chk(leak, 0);
        h = 0;
        for (int k = 0; k < 8; k++) begin
            d = 1;
            foreach (emps_ctl_model_inst.sent[i])
                if (emps_ctl_model_inst.got[k + i] != emps_ctl_model_inst.sent[i])
                    d = 0;
            h = h | d;
        end
        chk(h, 1);
        $display("loopback done");
        {loopback_en_i, tp_rx_active_i} <= 2'b01;
        cyc(40);
        emps_ctl_model_inst.send(40);
        cyc(1);
        chk({collision_out_o, tp_tx_en_o, aui_idle_o}, 3'b111);
        full_duplex_sel_n_i <= 0;
        cyc(400);
        emps_ctl_model_inst.send(40);
        cyc(1);
        chk({collision_out_o, tp_tx_en_o, aui_idle_o}, 3'b011);
        $display("duplex done");
        close_out;
    end
endmodule // tb_eth_xcvr_mode_port_select
`default_nettype wire
